//--- hdl/gchs_defines.vh
`ifndef GCHS_DEFINES_VH
`define GCHS_DEFINES_VH
// Channel count and field positions
`define GCHS_NUM_CH          17
`define GCHS_CH_MODE_BIT     0
`define GCHS_GPIO_DIR_LSB    0
`define GCHS_GPIO_LVL_LSB    2
`define GCHS_INT_PIN_LSB     2
// Interrupt pin configuration codes (bit0 = open drain, bit1 = active high)
`define GCHS_INT_OD_BIT      0
`define GCHS_INT_POL_BIT     1
// Reset sequence timing
`define GCHS_RESET_NS        2000
`define GCHS_CLK_NS          10
`define GCHS_RESET_CYC       (`GCHS_RESET_NS / `GCHS_CLK_NS)
`define GCHS_RESET_CW        8
// Host interface mode codes (one-hot)
`define GCHS_HIF_SERIAL      4'b0001
`define GCHS_HIF_PAR_DS      4'b0010
`define GCHS_HIF_PAR_RDWR    4'b0100
`define GCHS_HIF_IDLE        4'b1000
`endif

//--- hdl/gchs_gpio_cell.v
`default_nettype none
module gchs_gpio_cell (
   input  wire clock_in,
   input  wire rstn_in,
   input  wire dir_out_sel_in,
   input  wire level_wr_in,
   input  wire level_wr_data_in,
   input  wire pin_in,
   output wire pin_out,
   output wire pin_oe_n_out,
   output wire level_out
);
   reg drive_q;
   reg sample_q;
   always @(posedge clock_in) begin
      if (!rstn_in) begin
         drive_q  <= 1'b0;
         sample_q <= 1'b0;
      end else begin
         if (level_wr_in)
            drive_q <= level_wr_data_in;   // [RULE_07]
         sample_q <= pin_in;
      end
   end
   // Pin direction chosen by its own bit; enable is low while driving
   assign pin_oe_n_out = ~dir_out_sel_in;                    // [RULE_06]
   assign pin_out      = drive_q;
   assign level_out    = dir_out_sel_in ? drive_q : sample_q; // [RULE_07]
endmodule
`default_nettype wire

//--- hdl/gchs_int_pin.v
`default_nettype none
`include "gchs_defines.vh"
module gchs_int_pin (
   input  wire clock_in,
   input  wire rstn_in,
   input  wire pending_in,
   input  wire [1:0] cfg_in,
   output wire pin_out,
   output wire pin_oe_n_out
);
   reg req_q;
   always @(posedge clock_in) begin
      if (!rstn_in)
         req_q <= 1'b0;
      else
         req_q <= pending_in;
   end
   wire active_level = cfg_in[`GCHS_INT_POL_BIT];
   wire level        = req_q ? active_level : ~active_level;
   // Open drain only drives the pin toward its active level
   assign pin_out      = level;                                     // [RULE_10]
   assign pin_oe_n_out = cfg_in[`GCHS_INT_OD_BIT] ? (level != active_level) : 1'b0; // [RULE_10]
endmodule
`default_nettype wire

//--- hdl/gchs_top.v
// Function
// RULE_01 - Output enable high enables all line drivers; low forces them high impedance.
// RULE_02 - Output enable gates only driver outputs; internal logic keeps running.
// RULE_03 - Open mode-select enable: every channel mode comes from hardware mode pin.
// RULE_04 - Mode-select enable low: each channel uses its own config mode bit b0.
// RULE_05 - Hardware mode pin low means E1, open means T1/J1; ignored when disabled.
// RULE_06 - Each general-purpose pin direction follows its own bit in b1~0.
// RULE_07 - Level bits b3~2 report input level or set driven output level.
// RULE_08 - Low reset pulse resets device; sequence completes within 2 us.
// RULE_09 - Interrupt output asserts whenever any unmasked interrupt source is pending.
// RULE_10 - Interrupt pin drive type and polarity set by global config bits b3~2.
// RULE_11 - Host interface responds only while chip select is low.
// RULE_12 - Host drops chip select per operation and holds it until finished.
// RULE_13 - Interface strap low selects serial host interface, high selects parallel.
// RULE_14 - Serial uses select, clock, data in/out; parallel uses strobes, data, address.
// RULE_15 - Bus-style strap low picks data strobe style; open picks read/write strobes.
// RULE_16 - Unconnected pulled-up straps read high, same as a driven high level.
`default_nettype none
`include "gchs_defines.vh"
module gchs_top (
   input  wire        clock_in,
   input  wire        rstn_in,
   // Line driver control
   input  wire        output_enable_in,
   input  wire [16:0] drv_request_in,
   output wire [16:0] drv_enable_out,
   // Line mode selection (1 = E1, 0 = T1/J1)
   input  wire        hw_line_mode_select_enable_in,
   input  wire        hw_line_mode_select_in,
   input  wire [16:0] channel_line_mode_bit_in,
   output reg  [16:0] line_mode_e1_out,
   // General-purpose pins
   input  wire [3:0]  gpio_reg_wr_data_in,
   input  wire        gpio_reg_wr_in,
   input  wire [1:0]  gpio_pin_in,
   output wire [1:0]  gpio_pin_out,
   output wire [1:0]  gpio_pin_oe_n_out,
   output wire [3:0]  gpio_reg_rd_data_out,
   // Interrupts
   input  wire [15:0] irq_pending_in,
   input  wire [15:0] irq_mask_in,
   input  wire [3:0]  global_config_reg_in,
   output wire        irq_pin_out,
   output wire        irq_pin_oe_n_out,
   // Host interface selection
   input  wire        chip_select_n_in,
   input  wire        par_ser_strap_in,
   input  wire        parallel_bus_style_strap_in,
   input  wire        muxed_bus_select_in,
   output wire        host_access_en_out,
   output reg  [3:0]  host_if_mode_out,
   output wire        muxed_bus_out,
   output reg         reset_busy_out,
   output wire        device_ready_out
);
   ////////////////////////////////////////////////////////////////////////////////
   // Reset sequence: straps are sampled while the reset counter runs and held once it finishes
   reg [`GCHS_RESET_CW-1:0] rst_cnt_q;
   reg                      ser_strap_q;
   reg                      style_strap_q;
   reg                      mux_strap_q;
   wire                     rst_done = (rst_cnt_q == `GCHS_RESET_CW'd0);
   // Load value kept wide, then cut to the counter width on purpose
   wire [31:0]              rst_load = `GCHS_RESET_CYC - 1;
   always @(posedge clock_in) begin
      if (!rstn_in) begin
         rst_cnt_q      <= rst_load[`GCHS_RESET_CW-1:0]; // [RULE_08]
         reset_busy_out <= 1'b1;
         ser_strap_q    <= 1'b1;
         style_strap_q  <= 1'b1;
         mux_strap_q    <= 1'b1;
      end else if (!rst_done) begin
         rst_cnt_q      <= rst_cnt_q - `GCHS_RESET_CW'd1; // [RULE_08]
         reset_busy_out <= 1'b1;
         // Pulled-up straps float high, so open reads as high
         ser_strap_q    <= par_ser_strap_in;          // [RULE_16]
         style_strap_q  <= parallel_bus_style_strap_in; // [RULE_16]
         mux_strap_q    <= muxed_bus_select_in;
      end else begin
         reset_busy_out <= 1'b0;
      end
   end
   assign device_ready_out = ~reset_busy_out; // [RULE_08]

   ////////////////////////////////////////////////////////////////////////////////
   // Host interface mode
   always @(posedge clock_in) begin
      if (!rstn_in)
         host_if_mode_out <= `GCHS_HIF_IDLE;
      else if (!rst_done)
         host_if_mode_out <= `GCHS_HIF_IDLE;
      else begin
         case ({ser_strap_q, style_strap_q})
            2'b00,
            2'b01:   host_if_mode_out <= `GCHS_HIF_SERIAL;   // [RULE_13] [RULE_14]
            2'b10:   host_if_mode_out <= `GCHS_HIF_PAR_DS;   // [RULE_15]
            2'b11:   host_if_mode_out <= `GCHS_HIF_PAR_RDWR; // [RULE_15]
            default: host_if_mode_out <= `GCHS_HIF_IDLE;
         endcase
      end
   end
   assign muxed_bus_out = mux_strap_q & ser_strap_q;
   // Accesses need chip select low; host holds it for the whole cycle
   assign host_access_en_out = ~chip_select_n_in & ~reset_busy_out; // [RULE_11] [RULE_12]

   ////////////////////////////////////////////////////////////////////////////////
   // Line drivers and mode
   // Only the driver outputs are gated; modes keep running regardless
   assign drv_enable_out = drv_request_in & {17{output_enable_in}}; // [RULE_01] [RULE_02]
   always @(posedge clock_in) begin
      if (!rstn_in)
         line_mode_e1_out <= 17'h0_0000;
      else if (hw_line_mode_select_enable_in)
         line_mode_e1_out <= {17{~hw_line_mode_select_in}}; // [RULE_03] [RULE_05]
      else
         line_mode_e1_out <= channel_line_mode_bit_in;       // [RULE_04]
   end

   ////////////////////////////////////////////////////////////////////////////////
   // General-purpose pins
   reg [1:0] gpio_dir_q;
   wire [1:0] gpio_level;
   always @(posedge clock_in) begin
      if (!rstn_in)
         gpio_dir_q <= 2'b00;
      else if (gpio_reg_wr_in)
         gpio_dir_q <= gpio_reg_wr_data_in[`GCHS_GPIO_DIR_LSB +: 2]; // [RULE_06]
   end
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : gp
         gchs_gpio_cell u_cell (
            .clock_in         (clock_in),
            .rstn_in          (rstn_in),
            .dir_out_sel_in   (gpio_dir_q[g]),
            .level_wr_in      (gpio_reg_wr_in),
            .level_wr_data_in (gpio_reg_wr_data_in[`GCHS_GPIO_LVL_LSB + g]),
            .pin_in           (gpio_pin_in[g]),
            .pin_out          (gpio_pin_out[g]),
            .pin_oe_n_out     (gpio_pin_oe_n_out[g]),
            .level_out        (gpio_level[g])
         );
      end
   endgenerate
   assign gpio_reg_rd_data_out = {gpio_level, gpio_dir_q}; // [RULE_07]

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt pin
   wire irq_any = |(irq_pending_in & ~irq_mask_in); // [RULE_09]
   gchs_int_pin u_int (
      .clock_in     (clock_in),
      .rstn_in      (rstn_in),
      .pending_in   (irq_any),
      .cfg_in       (global_config_reg_in[`GCHS_INT_PIN_LSB +: 2]),
      .pin_out      (irq_pin_out),
      .pin_oe_n_out (irq_pin_oe_n_out)
   );
endmodule
`default_nettype wire

//--- bench/gchs_properties.sv
`default_nettype none
module gchs_properties (
   input wire logic        clock_in,
   input wire logic        rstn_in,
   input wire logic        output_enable_in,
   input wire logic        hw_line_mode_select_enable_in,
   input wire logic        hw_line_mode_select_in,
   input wire logic [16:0] channel_line_mode_bit_in,
   input wire logic [16:0] line_mode_e1_out,
   input wire logic [15:0] irq_pending_in,
   input wire logic [15:0] irq_mask_in,
   input wire logic        device_ready_out,
   input wire logic [16:0] drv_request_in,
   input wire logic [16:0] drv_enable_out,
   input wire logic [3:0]  gpio_reg_wr_data_in,
   input wire logic        gpio_reg_wr_in,
   input wire logic [1:0]  gpio_pin_oe_n_out,
   input wire logic [3:0]  global_config_reg_in,
   input wire logic        irq_pin_out,
   input wire logic        irq_pin_oe_n_out,
   input wire logic        chip_select_n_in,
   input wire logic        host_access_en_out,
   input wire logic        reset_busy_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rstn_in);
   chk_drv_gate: assert property (drv_enable_out == (drv_request_in & {17{output_enable_in}}))
      else $error("driver enable wrong");
   chk_oe_off: assert property (!output_enable_in |-> drv_enable_out == 17'h0)
      else $error("driver on with enable low");
   chk_gpio_dir: assert property (gpio_reg_wr_in |=> gpio_pin_oe_n_out == ~$past(gpio_reg_wr_data_in[1:0]))
      else $error("gpio direction wrong");
   // Config is only trusted once stable, the pin follows pending one cycle late
   chk_irq_push: assert property ($past(rstn_in) && $stable(global_config_reg_in) && !global_config_reg_in[2]
      |-> !irq_pin_oe_n_out) else $error("push-pull irq not driven");
   chk_irq_level: assert property ($past(rstn_in) && $stable(global_config_reg_in) && global_config_reg_in[2]
      && !irq_pin_oe_n_out |-> irq_pin_out == global_config_reg_in[3]) else $error("irq active level wrong");
   chk_host_gate: assert property (host_access_en_out == (!chip_select_n_in && !reset_busy_out))
      else $error("host access gate wrong");
   chk_reset_time: assert property ($rose(rstn_in) |-> ##[1:203] !reset_busy_out)
      else $error("reset sequence too long");
   chk_busy_hold: assert property ($rose(rstn_in) |-> reset_busy_out [*8])
      else $error("reset busy dropped early");
   chk_ready_flag: assert property (device_ready_out == !reset_busy_out)
      else $error("ready flag wrong");
   chk_line_mode: assert property ($past(rstn_in) |-> line_mode_e1_out == ($past(hw_line_mode_select_enable_in)
      ? {17{!$past(hw_line_mode_select_in)}} : $past(channel_line_mode_bit_in))) else $error("line mode wrong");
   chk_irq_follow: assert property ($past(rstn_in) && $stable(global_config_reg_in) |-> irq_pin_out ==
      ($past(|(irq_pending_in & ~irq_mask_in)) ? global_config_reg_in[3] : !global_config_reg_in[3]))
      else $error("irq pin does not follow pending");
endmodule
bind gchs_top gchs_properties gchs_properties_i (.*);
`default_nettype wire

//--- bench/gchs_host_model.sv
`default_nettype none
module gchs_host_model (
   input  wire logic clock_in,
   output var logic  chip_select_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial chip_select_n_out = 1'b1;
   // Select falls per access and holds to its end
   task automatic access(input int cycles);
      @(negedge clock_in);
      chip_select_n_out = 1'b0;
      repeat (cycles) @(negedge clock_in);
      chip_select_n_out = 1'b1;
   endtask
endmodule
`default_nettype wire

//--- bench/gchs_top_test.sv
`default_nettype none
module gchs_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock_in = 1'b0, rstn_in, oe, hw_en, hw_sel, wr, cs_n, par, sty, mux, act, muxo, ipin, ioe, hen, busy;
   logic [16:0] req, bits, drv, mode;
   logic [15:0] pend, mask;
   logic [3:0]  wdat, cfg, rd, imode;
   logic [1:0]  pin, gpo, goe, lv;
   logic [20:0] q[$];
   int          err_total = 0, n_tests = 0, k;
   string       nm[6] = '{"drv_en", "line_mode", "gpio", "irq", "host_en", "if_mode"};
   gchs_host_model gchs_host_model_i (.clock_in(clock_in), .chip_select_n_out(cs_n));
   gchs_top gchs_top_i (.clock_in(clock_in), .rstn_in(rstn_in), .output_enable_in(oe), .drv_request_in(req),
      .drv_enable_out(drv), .hw_line_mode_select_enable_in(hw_en), .hw_line_mode_select_in(hw_sel),
      .channel_line_mode_bit_in(bits), .line_mode_e1_out(mode), .gpio_reg_wr_data_in(wdat), .gpio_reg_wr_in(wr),
      .gpio_pin_in(pin), .gpio_pin_out(gpo), .gpio_pin_oe_n_out(goe), .gpio_reg_rd_data_out(rd),
      .irq_pending_in(pend), .irq_mask_in(mask), .global_config_reg_in(cfg), .irq_pin_out(ipin),
      .irq_pin_oe_n_out(ioe), .chip_select_n_in(cs_n), .par_ser_strap_in(par), .parallel_bus_style_strap_in(sty),
      .muxed_bus_select_in(mux), .host_access_en_out(hen), .host_if_mode_out(imode), .muxed_bus_out(muxo),
      .reset_busy_out(busy), .device_ready_out());
   initial forever #5 clock_in = ~clock_in;
   task automatic note(input logic [3:0] s, input logic [16:0] v);
      q.push_back({s, v});
   endtask
   task automatic check(input logic [20:0] e);
      logic [16:0] got;
      case (e[20:17])
         4'h0: got = drv;
         4'h1: got = mode;
         4'h2: got = {9'h0, rd, goe, gpo & ~goe};
         4'h3: got = {15'h0, ioe, ipin & ~ioe};
         4'h4: got = {16'h0, hen};
         default: got = {12'h0, muxo, imode};
      endcase
      n_tests++;
      if (e[16:0] !== got) begin
         err_total++;
         $display("MISMATCH %s exp %h got %h", nm[e[20:17]], e[16:0], got);
      end
   endtask
   task automatic summarize(input logic hung);
      err_total += int'(hung);
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Sampled 2 ns after the falling edge so no input is moving then
   initial forever begin
      @(negedge clock_in);
      #2;
      while (q.size() != 0) check(q.pop_front());
   end
   initial begin
      void'($urandom(32'hd3b1_3672));
      {rstn_in, wr, par, sty, mux, oe, hw_en, hw_sel, req, bits, pend, mask, wdat, cfg, pin} = '0;
      for (int s = 0; s < 3; s++) begin
         @(negedge clock_in);
         {rstn_in, par, sty, mux} = {1'b0, s != 0, s == 2, s == 1};
         repeat (5) @(negedge clock_in);
         rstn_in = 1'b1;
         for (k = 0; k < 203 && busy !== 1'b0; k++) @(negedge clock_in);
         if (busy !== 1'b0) summarize(1'b1);
         note(5, {12'h0, s == 1, s == 0 ? 4'h1 : s == 1 ? 4'h2 : 4'h4});
         $display("reset test %0d done", s);
      end
      for (int i = 0; i < 24; i++) begin
         @(negedge clock_in);
         {oe, hw_en, hw_sel, req, bits, pend, mask, wdat, cfg, pin} = 79'({$urandom, $urandom, $urandom});
         pend &= {16{i[1]}};
         act = |(pend & ~mask);
         lv = wdat[3:2] & wdat[1:0];
         wr = 1'b1;
         if (i[0]) fork gchs_host_model_i.access(2); join_none
         @(negedge clock_in);
         wr = 1'b0;
         note(0, req & {17{oe}});
         note(1, hw_en ? {17{~hw_sel}} : bits);
         note(2, {9'h0, lv | (pin & ~wdat[1:0]), wdat[1:0], ~wdat[1:0], lv});
         note(3, {15'h0, cfg[2] & ~act, ~(cfg[2] & ~act) & (act ^ ~cfg[3])});
         @(negedge clock_in);
         note(4, {16'h0, i[0]});
      end
      $display("random test done");
      #3;
      summarize(1'b0);
   end
endmodule
`default_nettype wire
